// ---- logic/serdes_analog_control_reg.sv ----
// wishbone classic slave holding the transceiver analog control register
// assumes one core clock; outputs are static levels to the transceiver lanes
// Summary of operation
// - tx equalization bits 3:0, reset 0x8
// - tx current scale bits 7:4, reset 0
// - tx nominal current bits 9:8, reset 0
// - tx termination adjust bits 11:10, reset 0
// - rx termination adjust bits 13:12, reset 0
// - supply voltage select bit 14, reset 0
// - rx equalization select bits 16:15, reset 0
`timescale 1ns/100ps
`default_nettype none
`include "serdes_analog_control_consts.svh"

module serdes_analog_control_reg (
  input  wire logic                                     clk,
  input  wire logic                                     reset_n,
  input  wire serdes_analog_control_pkg::wb_req_t       wb_req,
  output var  serdes_analog_control_pkg::wb_rsp_t       wb_rsp,
  output var  serdes_analog_control_pkg::serdes_analog_control_t lane_ctl
);
  import serdes_analog_control_pkg::*;

  // ****************************************
  // local sizes
  // ****************************************
  // stored width follows the field struct; nothing above it exists
  localparam int unsigned            CTL_W    = $bits(serdes_analog_control_t);
  localparam int unsigned            LANES    = 4;
  localparam int unsigned            LANE_W   = 8;
  localparam logic [`SAC_ADDR_W-1:0] REG_ADDR = `SAC_OFFSET;

  // ****************************************
  // address decode
  // ****************************************
  // word decode only; the two low address bits select nothing
  function automatic logic addr_hit(
    input logic [`SAC_ADDR_W-1:0] adr
  );
    logic hit;

    hit = (adr[`SAC_ADDR_W-1:2] == REG_ADDR[`SAC_ADDR_W-1:2]);

    return hit;
  endfunction : addr_hit

  // ****************************************
  // field packing
  // ****************************************
  // fields widened to the bus word; upper bits are forced to zero
  function automatic logic [31:0] to_word(
    input serdes_analog_control_t ctl
  );
    logic [31:0] w;

    w                                      = 32'h0000_0000;

    w[`SAC_TX_EQ_MSB:`SAC_TX_EQ_LSB]       = ctl.tx_equalization_level;
    w[`SAC_TX_SCALE_MSB:`SAC_TX_SCALE_LSB] = ctl.tx_current_scale_factor;

    w[`SAC_TX_NOM_MSB:`SAC_TX_NOM_LSB]     = ctl.tx_nominal_current_select;
    w[`SAC_TX_TERM_MSB:`SAC_TX_TERM_LSB]   = ctl.tx_termination_adjust;

    w[`SAC_RX_TERM_MSB:`SAC_RX_TERM_LSB]   = ctl.rx_termination_adjust;
    w[`SAC_SUPPLY_BIT]                     = ctl.supply_voltage_select;

    w[`SAC_RX_EQ_MSB:`SAC_RX_EQ_LSB]       = ctl.rx_equalization_select;

    return w;
  endfunction : to_word

  // bus word back to fields; bits 31:17 are never looked at
  function automatic serdes_analog_control_t from_word(
    input logic [31:0] w
  );
    serdes_analog_control_t c;

    // de-emphasis step, zero means none
    c.tx_equalization_level     = w[`SAC_TX_EQ_MSB:`SAC_TX_EQ_LSB];

    // multiplier applied to the nominal drive current
    c.tx_current_scale_factor   = w[`SAC_TX_SCALE_MSB:`SAC_TX_SCALE_LSB];

    // nominal drive current, code 3 kept as written
    c.tx_nominal_current_select = w[`SAC_TX_NOM_MSB:`SAC_TX_NOM_LSB];

    // transmit termination trim around nominal
    c.tx_termination_adjust     = w[`SAC_TX_TERM_MSB:`SAC_TX_TERM_LSB];

    // receive termination trim, same codes as transmit
    c.rx_termination_adjust     = w[`SAC_RX_TERM_MSB:`SAC_RX_TERM_LSB];

    // lane supply level select
    c.supply_voltage_select     = w[`SAC_SUPPLY_BIT];

    // receive equalization, code 3 kept as written
    c.rx_equalization_select    = w[`SAC_RX_EQ_MSB:`SAC_RX_EQ_LSB];

    return c;
  endfunction : from_word

  // ****************************************
  // read path
  // ****************************************
  // a miss reads as zero so that probing stays harmless
  function automatic logic [31:0] read_word(
    input logic                   hit,
    input serdes_analog_control_t ctl
  );
    logic [31:0] w;

    w = 32'h0000_0000;
    if (hit) begin
      w = to_word(ctl);
    end

    return w;
  endfunction : read_word

  // ****************************************
  // state
  // ****************************************
  // word layout, msb first:
  //   31:17 not stored, read as zero
  //   16:15 receive equalization
  //   14    supply level
  //   13:12 receive termination
  //   11:10 transmit termination
  //   9:8   nominal drive current
  //   7:4   drive current scale
  //   3:0   transmit de-emphasis
  sac_state_t       state_ff;
  sac_state_t       nxt_state;
  logic             req;
  logic             wr_hit;
  logic             rd_hit;
  logic [LANES-1:0] lane_en;
  logic [31:0]      cur_word;
  logic [31:0]      wr_word;

  // ****************************************
  // request qualification
  // ****************************************
  // ack is registered, so a request still held in the ack cycle is not
  // taken twice; the price is one idle cycle between transfers
  // edge 1 takes the request and updates the register, edge 2 sees ack
  assign req      = wb_req.cyc && wb_req.stb && !state_ff.ack;

  assign wr_hit   = req && wb_req.we && addr_hit(wb_req.adr);

  assign rd_hit   = req && !wb_req.we && addr_hit(wb_req.adr);

  assign cur_word = to_word(state_ff.ctl);

  // ****************************************
  // byte-lane merge
  // ****************************************
  // unselected lanes keep the stored bits; lane 3 holds nothing stored
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      assign lane_en[g] = wb_req.sel[g];

      assign wr_word[g*LANE_W +: LANE_W] = lane_en[g] ? wb_req.dat[g*LANE_W +: LANE_W]
                                                      : cur_word[g*LANE_W +: LANE_W];
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  // unmapped addresses ack with zero data; no error so probing stays harmless
  // writes to a miss are dropped; bits above the stored width never land
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.ack  = req;
    nxt_state.rdat = 32'h0000_0000;

    if (wr_hit) begin
      nxt_state.ctl = from_word(wr_word);
    end else if (rd_hit) begin
      nxt_state.rdat = read_word(rd_hit, state_ff.ctl);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff.ctl.tx_equalization_level     <= `SAC_TX_EQ_RESET;
      state_ff.ctl.tx_current_scale_factor   <= `SAC_TX_SCALE_RESET;
      state_ff.ctl.tx_nominal_current_select <= `SAC_TX_NOM_RESET;
      state_ff.ctl.tx_termination_adjust     <= `SAC_TX_TERM_RESET;
      state_ff.ctl.rx_termination_adjust     <= `SAC_RX_TERM_RESET;
      state_ff.ctl.supply_voltage_select     <= `SAC_SUPPLY_RESET;
      state_ff.ctl.rx_equalization_select    <= `SAC_RX_EQ_RESET;
      state_ff.ack                           <= 1'b0;
      state_ff.rdat                          <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // reserved codes are passed through untouched; the lanes decide what they mean
  assign lane_ctl.tx_equalization_level     = state_ff.ctl.tx_equalization_level;
  assign lane_ctl.tx_current_scale_factor   = state_ff.ctl.tx_current_scale_factor;
  assign lane_ctl.tx_nominal_current_select = state_ff.ctl.tx_nominal_current_select;
  assign lane_ctl.tx_termination_adjust     = state_ff.ctl.tx_termination_adjust;
  assign lane_ctl.rx_termination_adjust     = state_ff.ctl.rx_termination_adjust;
  assign lane_ctl.supply_voltage_select     = state_ff.ctl.supply_voltage_select;
  assign lane_ctl.rx_equalization_select    = state_ff.ctl.rx_equalization_select;

  assign wb_rsp.ack = state_ff.ack;
  assign wb_rsp.err = 1'b0;
  assign wb_rsp.dat = state_ff.rdat;

endmodule : serdes_analog_control_reg
`default_nettype wire

// ---- logic/serdes_analog_control_consts.svh ----
// register offset, field positions and reset values of the transceiver analog control register
// assumes a 32-bit wishbone data path with byte addresses
`ifndef SERDES_ANALOG_CONTROL_CONSTS_SVH
`define SERDES_ANALOG_CONTROL_CONSTS_SVH

`define SAC_ADDR_W              12
`define SAC_OFFSET              12'h200
`define SAC_TX_EQ_LSB           0
`define SAC_TX_EQ_MSB           3
`define SAC_TX_SCALE_LSB        4
`define SAC_TX_SCALE_MSB        7
`define SAC_TX_NOM_LSB          8
`define SAC_TX_NOM_MSB          9
`define SAC_TX_TERM_LSB         10
`define SAC_TX_TERM_MSB         11
`define SAC_RX_TERM_LSB         12
`define SAC_RX_TERM_MSB         13
`define SAC_SUPPLY_BIT          14
`define SAC_RX_EQ_LSB           15
`define SAC_RX_EQ_MSB           16
`define SAC_TX_EQ_RESET         4'h8
`define SAC_TX_SCALE_RESET      4'h0
`define SAC_TX_NOM_RESET        2'h0
`define SAC_TX_TERM_RESET       2'h0
`define SAC_RX_TERM_RESET       2'h0
`define SAC_SUPPLY_RESET        1'h0
`define SAC_RX_EQ_RESET         2'h0

`endif

// ---- logic/serdes_analog_control_pkg.sv ----
// types of the transceiver analog control register
// assumes the constants header is available on the include path
package serdes_analog_control_pkg;

  // field layout, msb first (bits 31:17 are not stored)
  typedef struct packed {
    logic [1:0] rx_equalization_select;
    logic       supply_voltage_select;
    logic [1:0] rx_termination_adjust;
    logic [1:0] tx_termination_adjust;
    logic [1:0] tx_nominal_current_select;
    logic [3:0] tx_current_scale_factor;
    logic [3:0] tx_equalization_level;
  } serdes_analog_control_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    serdes_analog_control_t ctl;
    logic                   ack;
    logic [31:0]            rdat;
  } sac_state_t;

endpackage : serdes_analog_control_pkg

// ---- verification/serdes_analog_control_monitor.sv ----
// bus and lane output checks for the analog control register
// assumes one core clock and binding to the register block
`timescale 1ns/100ps
`default_nettype none
// ****
// checks
// ****
module sac_monitor
  import serdes_analog_control_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire wb_req_t                wb_req,
  input wire wb_rsp_t                wb_rsp,
  input wire serdes_analog_control_t lane_ctl
);
  logic tk, wr, hit;
  assign tk = wb_req.cyc & wb_req.stb & !wb_rsp.ack;
  assign hit = wb_req.adr[11:2] == 10'h080;
  assign wr = tk & wb_req.we & hit;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_ans; tk ##1 wb_rsp.ack; endsequence
  property p_rst; $rose(reset_n) |-> lane_ctl == 17'h00008; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_ack; tk |-> s_ans; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_eq; wr & wb_req.sel[0] |=> lane_ctl[7:0] == $past(wb_req.dat[7:0]); endproperty
  a_eq: assert property (p_eq) else $error("byte 0");
  property p_mid; wr & wb_req.sel[1] |=> lane_ctl[15:8] == $past(wb_req.dat[15:8]); endproperty
  a_mid: assert property (p_mid) else $error("byte 1");
  property p_rx_equalization_select; wr & wb_req.sel[2] |=> lane_ctl[16] == $past(wb_req.dat[16]); endproperty
  a_rx_equalization_select: assert property (p_rx_equalization_select) else $error("bit 16");
  property p_hold; !wr |=> $stable(lane_ctl); endproperty
  a_hold: assert property (p_hold) else $error("moved");
  property p_rd; tk & !wb_req.we |=> wb_rsp.dat == ($past(hit) ? {15'h0, $past(lane_ctl)} : 32'h0);
  endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_err; wb_req.cyc |-> !wb_rsp.err; endproperty
  a_err: assert property (p_err) else $error("err raised");
  property p_idle; !wb_rsp.ack |-> wb_rsp.dat == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data outside ack");
endmodule : sac_monitor
bind serdes_analog_control_reg sac_monitor u_mon (.clk(clk), .reset_n(reset_n),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .lane_ctl(lane_ctl));
`default_nettype wire

// ---- verification/tb_serdes_analog_control_reg.sv ----
// self-checking bench of the analog control register
// assumes the package and constants header on the include path
`timescale 1ns/100ps
`default_nettype none
// ****
// bench
// ****
module tb_serdes_analog_control_reg;
  import serdes_analog_control_pkg::*;
  logic clk, reset_n;
  wb_req_t req;
  wb_rsp_t rsp;
  serdes_analog_control_t lane;
  logic [31:0] q[$], r, d;
  logic [16:0] m, bm;
  logic [11:0] a;
  integer seed = 49, error_cnt = 0, cmp_count = 0;
  serdes_analog_control_reg DUT (.clk(clk), .reset_n(reset_n), .wb_req(req), .wb_rsp(rsp),
    .lane_ctl(lane));
  task complete_run;
    $display("%0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [11:0] ad, input logic [3:0] s, input logic [31:0] dd);
    int n;
    if (!w) q.push_back(ad[11:2] == 10'h080 ? {15'h0, m} : 32'h0);
    req <= '{1'b1, 1'b1, w, s, ad, dd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 9);
    if (rsp.ack !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: no ack", $time);
      complete_run();
    end
    chk({31'h0, rsp.err}, 32'h0);
    bm = {s[2], {8{s[1]}}, {8{s[0]}}};
    if (w && ad[11:2] == 10'h080) m = (m & ~bm) | (dd[16:0] & bm);
    req <= '0;
    @(posedge clk);
    chk({15'h0, lane}, {15'h0, m});
  endtask : bus
  // reads are judged here as their ack shows, in issue order
  always @(negedge clk)
    if (rsp.ack === 1'b1 && req.we === 1'b0) chk(rsp.dat, q.pop_front());
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    req = '0;
    m = 17'h00008;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 12'h200, 4'hF, 32'h0);
    $display("reset test done");
    // all codes first, then random bytes, with random addresses on even passes only
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      d = i < 16 ? {8{i[3:0]}} : $random(seed);
      a = (i < 16 || i[0]) ? 12'h200 : r[11:0];
      bus(1'b1, a, i < 16 ? 4'hF : r[15:12], d);
      bus(1'b0, a, 4'hF, 32'h0);
    end
    $display("sweep test done");
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    m = 17'h00008;
    @(posedge clk);
    chk({15'h0, lane}, {15'h0, 17'h00008});
    bus(1'b0, 12'h200, 4'hF, 32'h0);
    $display("second reset test done");
    complete_run();
  end
endmodule : tb_serdes_analog_control_reg
`default_nettype wire
